// ---- logic/fsl_symbol_sublayer.sv ----
// Purpose: symbol sublayer between data-link logic and attachment unit
// Assumes: attachment unit toggles mau_sym_toggle once per received symbol
// Notes: registers over APB, one wait state per transfer
// Operation
// - four symbol values, non-data only in delimiters
// - lock when valid, well-timed symbols arrive
// - drop lock on idle, bad data, bad timing
// - lock stands before start delimiter is seen
// - frame valid on lock plus start delimiter
// - frame valid drops at next non-data symbol
// - carrier if seen in last four symbols
// - pass decoded symbols out while locked
// - normal status for delimiter, clean data, end
// - abort status on second start delimiter
// - invalid status on stray non-data symbol
// - node alarm at 8192 frame symbols
// - repeater alarm at 16384 frame symbols
// - alarm latched until clear or init
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "fsl_params.svh"
module fsl_symbol_sublayer #(
    parameter logic [14:0] OVERLEN_NODE_SYMS = 15'(`FSL_OVERLEN_NODE_SYMS),
    parameter logic [14:0] OVERLEN_REPEATER_SYMS = 15'(`FSL_OVERLEN_REPEATER_SYMS)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fsl_pkg::fsl_sym_t mau_rx_symbol,
    input wire logic mau_rx_valid,
    input wire logic mau_sym_toggle,
    input wire logic medium_carrier_in,
    output fsl_pkg::fsl_sym_t mau_tx_symbol,
    output logic mau_tx_enable,
    input wire fsl_pkg::fsl_sym_t tx_symbol_in,
    input wire logic tx_frame_active,
    output logic tx_symbol_taken,
    input wire logic source_node_select,
    input wire logic overlength_alarm_clear,
    output logic symbol_sync_flag,
    output logic rx_frame_valid,
    output logic carrier_present,
    output fsl_pkg::fsl_sym_t rx_symbol_out,
    output logic rx_symbol_strobe,
    output fsl_pkg::fsl_status_t rx_frame_status,
    output logic rx_status_strobe,
    output logic overlength_alarm
);
    import fsl_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic tog_prev;
        logic [5:0] gap_cnt;
        logic [5:0] st_cnt;
        logic [5:0] tx_cnt;
        logic lock;
        logic frame_valid;
        logic carrier;
        logic [`FSL_CARRIER_HIST-1:0] car_hist;
        fsl_sym_t rx_sym;
        logic rx_strobe;
        fsl_rx_state_t state;
        logic [3:0] tail_cnt;
        logic [14:0] sym_cnt;
        logic [14:0] last_len;
        fsl_status_t status;
        logic status_strobe;
        logic alarm;
        fsl_sym_t tx_sym;
        logic tx_en;
        logic tx_taken;
        logic ctrl_rx_en;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } fsl_top_st_t;

    fsl_top_st_t r;
    fsl_top_st_t next_r;

    function automatic fsl_sel_t fsl_decode(input logic [11:0] a);
        if (a == `FSL_REG_CTRL) begin
            return FSL_SEL_CTRL;
        end else if (a == `FSL_REG_STATUS) begin
            return FSL_SEL_STATUS;
        end else if (a == `FSL_REG_FRAME_LEN) begin
            return FSL_SEL_LEN;
        end else begin
            return FSL_SEL_NONE;
        end
    endfunction

    function automatic logic fsl_is_nondata(input fsl_sym_t s);
        return (s == `FSL_SYM_NONDATA_PLUS) || (s == `FSL_SYM_NONDATA_MINUS);
    endfunction

    // ----------------------------------------
    // pin synchronisers and delimiter matcher
    // ----------------------------------------
    // the symbol bits travel with the toggle; the unit holds them a whole
    // symbol, so they have settled by the time the toggle edge is seen
    logic [4:0] pins_q;
    fsl_sym_t q_sym;
    logic q_valid;
    logic q_tog;
    logic q_car;

    fsl_sync2 #(
        .W(5)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d({mau_rx_symbol, mau_rx_valid, mau_sym_toggle, medium_carrier_in}),
        .q(pins_q)
    );

    assign q_sym = pins_q[4:3];
    assign q_valid = pins_q[2];
    assign q_tog = pins_q[1];
    assign q_car = pins_q[0];

    logic rx_tick;
    logic next_lock;
    logic dtick;
    logic init_req;
    logic sd_hit;
    logic ed_hit;

    fsl_delim_match u_delim (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .clr(init_req || !next_lock),
        .tick(dtick),
        .sym(q_sym),
        .sd_hit(sd_hit),
        .ed_hit(ed_hit)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic acc;
    fsl_sel_t sel;
    logic wr_fire;
    logic clr_req;
    logic spacing_ok;
    logic sym_time;
    logic tx_tick;
    logic alarm_set;
    logic [14:0] cnt_inc;
    logic [14:0] thr;
    logic [31:0] rd;

    always_comb begin
        next_r = r;
        acc = psel && penable;
        sel = fsl_decode(paddr);
        wr_fire = acc && r.pready && pwrite && (sel == FSL_SEL_CTRL);
        init_req = wr_fire && pwdata[`FSL_CTRL_INIT];
        clr_req = overlength_alarm_clear || (wr_fire && pwdata[`FSL_CTRL_ALARM_CLR]);
        alarm_set = 1'b0;
        cnt_inc = (r.sym_cnt == 15'h7FFF) ? r.sym_cnt : r.sym_cnt + 15'h0001;
        thr = source_node_select ? OVERLEN_NODE_SYMS : OVERLEN_REPEATER_SYMS;
        rd = '0;

        // ---- symbol timing and lock ----
        rx_tick = (q_tog != r.tog_prev) && r.ctrl_rx_en;
        next_r.tog_prev = q_tog;
        spacing_ok = (r.gap_cnt >= 6'(`FSL_SYM_MIN_CYC)) &&
                     (r.gap_cnt <= 6'(`FSL_SYM_MAX_CYC));
        if (rx_tick) begin
            next_r.gap_cnt = 6'h01;
        end else if (r.gap_cnt != 6'h3F) begin
            next_r.gap_cnt = r.gap_cnt + 6'h01;
        end
        // the first symbol after silence has no interval to judge, so lock
        // comes with the second; the preamble covers this
        if (init_req) begin
            next_lock = 1'b0;
        end else if (rx_tick) begin
            next_lock = q_valid && spacing_ok;
        end else if (r.gap_cnt > 6'(`FSL_SYM_MAX_CYC)) begin
            next_lock = 1'b0;
        end else begin
            next_lock = r.lock;
        end
        next_r.lock = next_lock;
        dtick = rx_tick && next_lock;

        // ---- symbol output ----
        next_r.rx_strobe = dtick;
        if (dtick) begin
            next_r.rx_sym = q_sym;
        end

        // ---- carrier history, one step per symbol time ----
        sym_time = 1'b0;
        if (rx_tick) begin
            next_r.st_cnt = '0;
            sym_time = 1'b1;
        end else if (r.st_cnt == 6'(`FSL_SYM_CYC - 1)) begin
            next_r.st_cnt = '0;
            sym_time = 1'b1;
        end else begin
            next_r.st_cnt = r.st_cnt + 6'h01;
        end
        if (init_req) begin
            next_r.car_hist = '0;
            next_r.carrier = 1'b0;
        end else if (sym_time) begin
            next_r.car_hist = {r.car_hist[`FSL_CARRIER_HIST-2:0], q_car};
            next_r.carrier = |next_r.car_hist;
        end

        // ---- frame tracking ----
        next_r.status_strobe = 1'b0;
        if (init_req || !next_lock) begin
            next_r.frame_valid = 1'b0;
            next_r.state = FSL_RX_IDLE;
            next_r.sym_cnt = '0;
            if (init_req) begin
                next_r.status = FSL_STATUS_NONE;
            end
        end else if (dtick) begin
            case (r.state)
                FSL_RX_IDLE: begin
                    if (sd_hit && r.lock) begin
                        next_r.frame_valid = 1'b1;
                        next_r.state = FSL_RX_DATA;
                        next_r.sym_cnt = '0;
                    end
                end
                FSL_RX_DATA: begin
                    if (fsl_is_nondata(q_sym)) begin
                        next_r.frame_valid = 1'b0;
                        next_r.state = FSL_RX_TAIL;
                        next_r.tail_cnt = 4'h1;
                        next_r.last_len = r.sym_cnt;
                        next_r.sym_cnt = '0;
                    end else begin
                        next_r.sym_cnt = cnt_inc;
                        alarm_set = (cnt_inc >= thr);
                    end
                end
                FSL_RX_TAIL: begin
                    next_r.tail_cnt = r.tail_cnt + 4'h1;
                    if (sd_hit) begin
                        next_r.status = FSL_STATUS_ABORT;
                        next_r.status_strobe = 1'b1;
                        next_r.state = FSL_RX_IDLE;
                    end else if (ed_hit) begin
                        next_r.status = FSL_STATUS_NORMAL;
                        next_r.status_strobe = 1'b1;
                        next_r.state = FSL_RX_IDLE;
                    end else if (r.tail_cnt == 4'(`FSL_DELIM_LEN)) begin
                        // no delimiter can still complete around this symbol
                        next_r.status = FSL_STATUS_INVALID;
                        next_r.status_strobe = 1'b1;
                        next_r.state = FSL_RX_IDLE;
                    end
                end
                default: begin
                    next_r.state = FSL_RX_IDLE;
                end
            endcase
        end

        // ---- over-length alarm, set wins over clear ----
        next_r.alarm = (r.alarm && !clr_req && !init_req) || alarm_set;

        // ---- transmit path, one symbol per symbol time ----
        tx_tick = (r.tx_cnt == 6'(`FSL_SYM_CYC - 1));
        next_r.tx_cnt = tx_tick ? 6'h00 : r.tx_cnt + 6'h01;
        next_r.tx_taken = 1'b0;
        if (init_req) begin
            next_r.tx_en = 1'b0;
            next_r.tx_sym = `FSL_SYM_ZERO;
        end else if (tx_tick) begin
            // an idle data-link side already drives zero; forcing it keeps
            // the line quiet even if it does not
            next_r.tx_sym = tx_frame_active ? tx_symbol_in : `FSL_SYM_ZERO;
            next_r.tx_en = tx_frame_active;
            next_r.tx_taken = tx_frame_active;
        end

        // ---- APB slave ----
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        if (acc && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.pslverr = (sel == FSL_SEL_NONE);
            if (sel == FSL_SEL_CTRL) begin
                rd[`FSL_CTRL_RX_EN] = r.ctrl_rx_en;
            end else if (sel == FSL_SEL_STATUS) begin
                rd[`FSL_STAT_LOCK] = r.lock;
                rd[`FSL_STAT_FRAME] = r.frame_valid;
                rd[`FSL_STAT_CARRIER] = r.carrier;
                rd[`FSL_STAT_ALARM] = r.alarm;
                rd[`FSL_STAT_STATUS_LSB +: 2] = r.status;
            end else if (sel == FSL_SEL_LEN) begin
                rd[14:0] = r.last_len;
            end
            next_r.prdata = pwrite ? 32'h0000_0000 : rd;
        end
        if (wr_fire) begin
            next_r.ctrl_rx_en = pwdata[`FSL_CTRL_RX_EN];
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.ctrl_rx_en <= `FSL_CTRL_RESET;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign mau_tx_symbol = r.tx_sym;
    assign mau_tx_enable = r.tx_en;
    assign tx_symbol_taken = r.tx_taken;
    assign symbol_sync_flag = r.lock;
    assign rx_frame_valid = r.frame_valid;
    assign carrier_present = r.carrier;
    assign rx_symbol_out = r.rx_sym;
    assign rx_symbol_strobe = r.rx_strobe;
    assign rx_frame_status = r.status;
    assign rx_status_strobe = r.status_strobe;
    assign overlength_alarm = r.alarm;
endmodule

// ---- logic/fsl_params.svh ----
// Purpose: constants of the fieldbus symbol sublayer
// Assumes: 40 MHz pclk
// Notes: included by its bare name
`ifndef FSL_PARAMS_SVH
`define FSL_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define FSL_CLK_MHZ 40
`define FSL_SYM_PERIOD_NS 1000
`define FSL_SYM_MIN_NS 900
`define FSL_SYM_MAX_NS 1100
`define FSL_SYM_CYC ((`FSL_SYM_PERIOD_NS * `FSL_CLK_MHZ) / 1000)
`define FSL_SYM_MIN_CYC ((`FSL_SYM_MIN_NS * `FSL_CLK_MHZ + 999) / 1000)
`define FSL_SYM_MAX_CYC ((`FSL_SYM_MAX_NS * `FSL_CLK_MHZ) / 1000)
`define FSL_CARRIER_HIST 4
`define FSL_OVERLEN_NODE_OCTETS 1024
`define FSL_OVERLEN_REPEATER_OCTETS 2048
`define FSL_OVERLEN_NODE_SYMS (`FSL_OVERLEN_NODE_OCTETS * 8)
`define FSL_OVERLEN_REPEATER_SYMS (`FSL_OVERLEN_REPEATER_OCTETS * 8)

// ----------------------------------------
// symbols and delimiters
// ----------------------------------------
`define FSL_SYM_ZERO 2'h0
`define FSL_SYM_ONE 2'h1
`define FSL_SYM_NONDATA_PLUS 2'h2
`define FSL_SYM_NONDATA_MINUS 2'h3
`define FSL_DELIM_LEN 8
`define FSL_SD_PATTERN 16'h6D38
`define FSL_ED_PATTERN 16'h6ED1

// ----------------------------------------
// registers
// ----------------------------------------
`define FSL_REG_CTRL 12'h000
`define FSL_REG_STATUS 12'h004
`define FSL_REG_FRAME_LEN 12'h008
`define FSL_CTRL_RX_EN 0
`define FSL_CTRL_ALARM_CLR 1
`define FSL_CTRL_INIT 2
`define FSL_STAT_LOCK 0
`define FSL_STAT_FRAME 1
`define FSL_STAT_CARRIER 2
`define FSL_STAT_ALARM 3
`define FSL_STAT_STATUS_LSB 4
`define FSL_CTRL_RESET 1'b1

`endif

// ---- logic/fsl_pkg.sv ----
// Purpose: types of the fieldbus symbol sublayer
// Assumes: nothing
// Notes: constants live in fsl_params.svh
package fsl_pkg;
    typedef logic [1:0] fsl_sym_t;
    typedef enum logic [1:0] {
        FSL_STATUS_NONE,
        FSL_STATUS_NORMAL,
        FSL_STATUS_ABORT,
        FSL_STATUS_INVALID
    } fsl_status_t;
    typedef enum logic [1:0] {
        FSL_RX_IDLE,
        FSL_RX_DATA,
        FSL_RX_TAIL
    } fsl_rx_state_t;
    typedef enum logic [1:0] {
        FSL_SEL_NONE,
        FSL_SEL_CTRL,
        FSL_SEL_STATUS,
        FSL_SEL_LEN
    } fsl_sel_t;
endpackage

// ---- logic/fsl_sync2.sv ----
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: multi-bit use only for bits held stable around a toggle
// Notes: stage one is read by stage two only
`timescale 1ns/1ps
module fsl_sync2 #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fsl_sync_st_t;

    fsl_sync_st_t r;
    fsl_sync_st_t next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule

// ---- logic/fsl_delim_match.sv ----
// Purpose: spots start and end delimiters in the symbol stream
// Assumes: tick marks one accepted symbol
// Notes: hits are combinational from history plus the current symbol
`timescale 1ns/1ps
`include "fsl_params.svh"
module fsl_delim_match (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic clr,
    input wire logic tick,
    input wire fsl_pkg::fsl_sym_t sym,
    output logic sd_hit,
    output logic ed_hit
);
    import fsl_pkg::*;

    typedef struct packed {
        logic [2*`FSL_DELIM_LEN-3:0] hist;
    } fsl_delim_st_t;

    fsl_delim_st_t r;
    fsl_delim_st_t next_r;
    logic [2*`FSL_DELIM_LEN-1:0] window;

    always_comb begin
        window = {r.hist, sym};
        next_r = r;
        if (clr) begin
            next_r.hist = '0;
        end else if (tick) begin
            next_r.hist = window[2*`FSL_DELIM_LEN-3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign sd_hit = tick && !clr && (window == `FSL_SD_PATTERN);
    assign ed_hit = tick && !clr && (window == `FSL_ED_PATTERN);
endmodule

// ---- test/fsl_symbol_sublayer_monitor.sv ----
// Purpose: port-level checker for the symbol sublayer
// Assumes: ce held high, single pclk domain
// Notes: bound into the top module below
`timescale 1ns/1ps
module fsl_symbol_sublayer_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic mau_sym_toggle,
    input wire logic medium_carrier_in,
    input wire fsl_pkg::fsl_sym_t mau_tx_symbol,
    input wire logic mau_tx_enable,
    input wire logic tx_symbol_taken,
    input wire logic overlength_alarm_clear,
    input wire logic symbol_sync_flag,
    input wire logic rx_frame_valid,
    input wire logic carrier_present,
    input wire logic rx_symbol_strobe,
    input wire fsl_pkg::fsl_status_t rx_frame_status,
    input wire logic rx_status_strobe,
    input wire logic overlength_alarm
);
    import fsl_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // saturating cycle counters: carrier high, carrier low, no toggle
    logic [7:0] car_hi, car_lo, quiet;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            car_hi <= 8'h00;
            car_lo <= 8'h00;
            quiet <= 8'h00;
        end else begin
            car_hi <= !medium_carrier_in ? 8'h00 : car_hi + 8'(car_hi != 8'hFF);
            car_lo <= medium_carrier_in ? 8'h00 : car_lo + 8'(car_lo != 8'hFF);
            quiet <= $changed(mau_sym_toggle) ? 8'h00 : quiet + 8'(quiet != 8'hFF);
        end
    end
    sequence s_access;
        psel && penable && !pready && ce;
    endsequence
    // completing control write, kept as a plain signal so that $past can look back at it
    logic ctrl_wr;
    assign ctrl_wr = psel && penable && pready && pwrite && (paddr == 12'h000);
    property p_one_wait;
        s_access |=> pready;
    endproperty
    property p_frame_after_lock;
        $rose(rx_frame_valid) |-> $past(symbol_sync_flag);
    endproperty
    property p_frame_lock_loss;
        $fell(symbol_sync_flag) |-> ##[0:1] !rx_frame_valid;
    endproperty
    property p_status_after_frame;
        rx_status_strobe |-> rx_frame_status != FSL_STATUS_NONE && !rx_frame_valid;
    endproperty
    property p_alarm_in_frame;
        $rose(overlength_alarm) |-> $past(rx_frame_valid);
    endproperty
    property p_alarm_latched;
        $fell(overlength_alarm) |-> $past(overlength_alarm_clear) || $past(ctrl_wr)
            || $past(ctrl_wr, 2);
    endproperty
    property p_tx_idle_zero;
        !mau_tx_enable |-> mau_tx_symbol == 2'h0;
    endproperty
    property p_taken_active;
        tx_symbol_taken |-> mau_tx_enable;
    endproperty
    property p_carrier_on;
        car_hi >= 8'd60 |-> carrier_present;
    endproperty
    property p_carrier_off;
        car_lo >= 8'd240 |-> !carrier_present;
    endproperty
    property p_lock_quiet;
        quiet >= 8'd52 |-> !symbol_sync_flag && !rx_symbol_strobe;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready late");
    a_frame_after_lock: assert property (p_frame_after_lock)
        else $error("frame valid without lock");
    a_frame_lock_loss: assert property (p_frame_lock_loss)
        else $error("frame valid kept after lock loss");
    a_status_after_frame: assert property (p_status_after_frame)
        else $error("bad status strobe");
    a_alarm_in_frame: assert property (p_alarm_in_frame)
        else $error("alarm outside frame");
    a_alarm_latched: assert property (p_alarm_latched)
        else $error("alarm fell without clear");
    a_tx_idle_zero: assert property (p_tx_idle_zero)
        else $error("idle tx symbol not zero");
    a_taken_active: assert property (p_taken_active)
        else $error("taken while idle");
    a_carrier_on: assert property (p_carrier_on)
        else $error("carrier missed");
    a_carrier_off: assert property (p_carrier_off)
        else $error("carrier stuck");
    a_lock_quiet: assert property (p_lock_quiet)
        else $error("lock held on silent line");
endmodule

bind fsl_symbol_sublayer fsl_symbol_sublayer_monitor mon_u (.*);

// ---- test/fsl_mau_model.sv ----
// Purpose: attachment unit model feeding received symbols
// Assumes: one symbol every 40 pclk cycles
// Notes: silent between frames, toggle stands still then
`timescale 1ns/1ps
module fsl_mau_model (
    input wire logic pclk,
    output fsl_pkg::fsl_sym_t mau_rx_symbol,
    output logic mau_rx_valid,
    output logic mau_sym_toggle,
    output logic medium_carrier_in
);
    import fsl_pkg::*;
    initial begin
        mau_rx_symbol = 2'h0;
        mau_rx_valid = 1'b0;
        mau_sym_toggle = 1'b0;
        medium_carrier_in = 1'b0;
    end
    // symbol settles a cycle ahead of its toggle and holds the whole period
    task automatic send(input fsl_sym_t s);
        @(posedge pclk);
        mau_rx_symbol <= s;
        mau_rx_valid <= 1'b1;
        medium_carrier_in <= 1'b1;
        @(posedge pclk);
        mau_sym_toggle <= ~mau_sym_toggle;
        repeat (38) @(posedge pclk);
    endtask
    task automatic pat(input logic [15:0] p);
        for (int i = 7; i >= 0; i--) begin
            send(fsl_sym_t'(p[2*i +: 2]));
        end
    endtask
    // released line shows the inverse of its last symbol, not a stale copy
    task automatic quiet(input int n);
        @(posedge pclk);
        mau_rx_symbol <= ~mau_rx_symbol;
        mau_rx_valid <= 1'b0;
        medium_carrier_in <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
endmodule

// ---- test/test_fsl_symbol_sublayer.sv ----
// Purpose: self-checking bench of the symbol sublayer
// Assumes: alarm thresholds shrunk to 20 and 40 symbols
// Notes: attachment unit model sits on the receive pins
`timescale 1ns/1ps
`include "fsl_params.svh"
module test_fsl_symbol_sublayer;
    import fsl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mau_rx_valid;
    logic mau_sym_toggle, medium_carrier_in, mau_tx_enable, tx_frame_active;
    logic tx_symbol_taken, source_node_select, overlength_alarm_clear, overlength_alarm;
    logic symbol_sync_flag, rx_frame_valid, carrier_present, rx_symbol_strobe;
    logic rx_status_strobe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    fsl_sym_t mau_rx_symbol, mau_tx_symbol, tx_symbol_in, rx_symbol_out;
    fsl_status_t rx_frame_status;
    int n_errors = 0;
    int comparisons = 0;
    fsl_symbol_sublayer #(
        .OVERLEN_NODE_SYMS(15'h0014),
        .OVERLEN_REPEATER_SYMS(15'h0028)
    ) dut_u (.ce(1'b1), .*);
    fsl_mau_model mau_u (.*);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic guard(input int i);
        if (i >= 60) begin
            n_errors++;
            stop_test;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 60);
        guard(i);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // preamble, start delimiter, n data symbols, then the given tail
    task automatic frame(input int n, input logic [15:0] tail, input logic [1:0] st,
                         input logic al);
        logic [31:0] q;
        logic e;
        repeat (3) mau_u.send(`FSL_SYM_ONE);
        chk("lock", symbol_sync_flag, 1'b1);
        mau_u.pat(`FSL_SD_PATTERN);
        for (int i = 0; i < n; i++) begin
            mau_u.send(fsl_sym_t'(i % 2));
        end
        chk("frame_valid", rx_frame_valid, 1'b1);
        chk("carrier", carrier_present, 1'b1);
        chk("rx_symbol", rx_symbol_out, (n - 1) % 2);
        mau_u.pat(tail);
        mau_u.send(`FSL_SYM_ZERO);
        chk("frame_end", rx_frame_valid, 1'b0);
        chk("status", rx_frame_status, st);
        mau_u.quiet(300);
        apb(1'b0, `FSL_REG_STATUS, 32'h0, q, e);
        chk("status_reg", q, {26'h000_0000, st, al, 3'h0});
        if (st == 2'h1) begin
            apb(1'b0, `FSL_REG_FRAME_LEN, 32'h0, q, e);
            // the end delimiter opens with a data one, counted before the frame drops
            chk("frame_len", q, n + 1);
        end
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic e;
        apb(1'b0, `FSL_REG_CTRL, 32'h0, q, e);
        chk("ctrl_reset", q, 32'h1);
        apb(1'b0, 12'h00C, 32'h0, q, e);
        chk("unmapped_err", e, 1'b1);
        chk("unmapped_data", q, 32'h0);
        apb(1'b1, `FSL_REG_STATUS, 32'hFFFF_FFFF, q, e);
        apb(1'b0, `FSL_REG_STATUS, 32'h0, q, e);
        chk("status_ro", q, 32'h0);
        apb(1'b1, `FSL_REG_CTRL, 32'h0, q, e);
        repeat (3) mau_u.send(`FSL_SYM_ONE);
        chk("rx_disabled", symbol_sync_flag, 1'b0);
        apb(1'b1, `FSL_REG_CTRL, 32'h1, q, e);
    endtask
    task automatic t_frames;
        frame(6, `FSL_ED_PATTERN, 2'h1, 1'b0);
        frame(4, `FSL_SD_PATTERN, 2'h2, 1'b0);
        frame(3, 16'h8000, 2'h3, 1'b0);
    endtask
    task automatic t_alarm;
        logic [31:0] q;
        logic e;
        // n data symbols plus the delimiter's leading one reach the count
        frame(18, `FSL_ED_PATTERN, 2'h1, 1'b0);
        frame(19, `FSL_ED_PATTERN, 2'h1, 1'b1);
        overlength_alarm_clear <= 1'b1;
        @(posedge pclk);
        overlength_alarm_clear <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("alarm_pin_clear", overlength_alarm, 1'b0);
        source_node_select <= 1'b0;
        frame(38, `FSL_ED_PATTERN, 2'h1, 1'b0);
        frame(39, `FSL_ED_PATTERN, 2'h1, 1'b1);
        apb(1'b1, `FSL_REG_CTRL, 32'h3, q, e);
        repeat (3) @(posedge pclk);
        chk("alarm_reg_clear", overlength_alarm, 1'b0);
        frame(39, `FSL_ED_PATTERN, 2'h1, 1'b1);
        apb(1'b1, `FSL_REG_CTRL, 32'h5, q, e);
        apb(1'b0, `FSL_REG_STATUS, 32'h0, q, e);
        chk("init_clears", q, 32'h0);
    endtask
    task automatic t_tx;
        int i;
        tx_frame_active <= 1'b1;
        tx_symbol_in <= `FSL_SYM_ONE;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (tx_symbol_taken !== 1'b1 && i < 60);
        guard(i);
        chk("tx_symbol", mau_tx_symbol, `FSL_SYM_ONE);
        chk("tx_enable", mau_tx_enable, 1'b1);
        tx_frame_active <= 1'b0;
        tx_symbol_in <= `FSL_SYM_ZERO;
        repeat (45) @(posedge pclk);
        chk("tx_idle", {mau_tx_enable, mau_tx_symbol}, 3'h0);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tx_symbol_in = `FSL_SYM_ZERO;
        tx_frame_active = 1'b0;
        source_node_select = 1'b1;
        overlength_alarm_clear = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_frames;
        t_alarm;
        t_tx;
        stop_test;
    end
endmodule
